// ===== hw/clock_bus_params.svh
/*
 Constants for the clock, ready, reset and local bus control block.
 Assumes inclusion by its bare name from the design.
*/
`ifndef CLOCK_BUS_PARAMS_SVH
`define CLOCK_BUS_PARAMS_SVH

// Processor clocks reset_sync_out stays high after the request ends
`define RESET_HOLD_CLKS 3'h5
// Processor clocks the strobe and status pins are driven at reset before floating
`define RESET_DRIVE_CLKS 2'h1
// Passive cycle status, all lines high
`define STATUS_PASSIVE 3'h7
// Oscillator periods per processor clock period
`define OSC_DIVIDE 2

`endif

// ===== hw/clock_bus_pkg.sv
/*
 Types for the clock, ready, reset and local bus control block.
 Assumes the params header is on the include path.
*/
package clock_bus_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_T1,
        ST_T2,
        ST_T3,
        ST_TW,
        ST_T4,
        ST_FLOAT,
        ST_HOLD
    } bus_state_t;

endpackage

// ===== hw/clock_bus_ctrl.sv
/*
 Clock generator, ready synchronisation, reset synchroniser and local
 bus controller of the processor, on one fast clock clk.
 Assumes the oscillator is far slower than clk, pins are resolved
 from out/oe pairs by the surroundings, and the core side issues
 one bus cycle at a time through req_valid/req_taken.
*/
`timescale 1ns/1ps
`include "clock_bus_params.svh"

// Summary of operation
// - Processor clock is the oscillator divided by two, 50% duty.
// - Divider toggles on each falling edge of the oscillator input.
// - Processor clock is driven out; all bus timing follows it.
// - Async ready sampled mid T2, T3 and each wait until high.
// - Async ready waits half a processor clock before use.
// - Only rising async ready is synchronised; falls come synchronous.
// - Sync ready sampled at end of T3 and waits.
// - Reset out lasts the reset request plus five clocks after it ends.
// - Reset out may lag the request by the sync plus one clock.
// - Reset request restarts the processor and the divider.
// - Address latch strobe, read and write strobes time transfers.
// - No memory or I/O select output is provided.
// - Transceiver enable low during memory, I/O and acknowledge cycles.
// - One bus request and grant pair; outside logic arbitrates.
// - Granted away, strobes, status, lock, buses and direction float.
// - Request beats fetch and DMA; running DMA finishes first.
// - No grant inside a locked transfer sequence.
// - At reset enable and strobes driven high one clock, then float.
// - At reset status and lock driven high then float; buses float.
// - At reset address latch strobe low, never floated; grant low.
// - Read strobe held high during reset.
module clock_bus_ctrl (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Clock and reset pins
    input wire logic oscillator_input,
    input wire logic reset_request_n,
    output logic processor_clock_out,
    output logic reset_sync_out,
    // Ready pins
    input wire logic async_ready_in,
    input wire logic sync_ready_in,
    // Arbitration pins
    input wire logic bus_request_in,
    output logic bus_grant_out,
    // Strobes
    output logic address_latch_strobe,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic transceiver_enable_n,
    output logic strobe_oe,
    // Status and lock
    output logic [2:0] cycle_status,
    output logic bus_lock_n,
    output logic status_oe,
    // Address, data and direction
    input wire logic [15:0] addr_data_in,
    output logic [15:0] addr_data_out,
    output logic addr_data_oe,
    output logic [3:0] upper_address,
    output logic high_byte_enable_n,
    output logic transfer_direction,
    output logic bus_oe,
    // Core side cycle request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_status,
    input wire logic [19:0] req_addr,
    input wire logic [15:0] req_wdata,
    input wire logic req_bhe_n,
    input wire logic req_lock,
    input wire logic req_dma_more,
    output logic req_taken,
    output logic cyc_done,
    output logic [15:0] cyc_rdata
);

    clock_bus_pkg::bus_state_t state_reg;
    logic [1:0] osc_sync;
    logic [1:0] res_sync;
    logic [1:0] async_ready_in_sync;
    logic [1:0] sync_ready_in_sync;
    logic [1:0] hold_sync;
    logic [15:0] ad_sync1;
    logic [15:0] ad_sync2;
    logic osc_prev;
    logic pclk_reg;
    logic pc_rise;
    logic pc_fall;
    logic res_prev;
    logic res_edge;
    logic [2:0] rst_cnt_reg;
    logic [1:0] drive_cnt_reg;
    logic async_ready_in_reg;
    logic ready_now;
    logic write_reg;
    logic lock_reg;
    logic keep_reg;
    logic [2:0] status_reg;
    logic [19:0] addr_reg;
    logic [15:0] wdata_reg;
    logic bhe_reg;
    logic grant_ok;
    logic in_cycle;

    // Two-flop synchronisers for every pin input
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_sync <= 2'h0;
            res_sync <= 2'h3;
            async_ready_in_sync <= 2'h0;
            sync_ready_in_sync <= 2'h0;
            hold_sync <= 2'h0;
            ad_sync1 <= 16'h0000;
            ad_sync2 <= 16'h0000;
        end else begin
            osc_sync <= {osc_sync[0], oscillator_input};
            res_sync <= {res_sync[0], reset_request_n};
            async_ready_in_sync <= {async_ready_in_sync[0], async_ready_in};
            sync_ready_in_sync <= {sync_ready_in_sync[0], sync_ready_in};
            hold_sync <= {hold_sync[0], bus_request_in};
            ad_sync1 <= addr_data_in;
            ad_sync2 <= ad_sync1;
        end
    end

    // Edge history of synchronised oscillator and reset request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_prev <= 1'b0;
            res_prev <= 1'b1;
        end else begin
            osc_prev <= osc_sync[1];
            res_prev <= res_sync[1];
        end
    end

    assign res_edge = res_prev && !res_sync[1];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_reg <= 1'b0;
        end else if (res_edge) begin
            pclk_reg <= 1'b0;
        end else if (osc_prev && !osc_sync[1]) begin
            pclk_reg <= !pclk_reg;
        end
    end

    assign pc_rise = osc_prev && !osc_sync[1] && !pclk_reg && !res_edge;
    assign pc_fall = osc_prev && !osc_sync[1] && pclk_reg && !res_edge;

    assign processor_clock_out = pclk_reg;

    // stretch reset out by five clocks
    // reset out within sync plus one clock
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_sync_out <= 1'b1;
            rst_cnt_reg <= `RESET_HOLD_CLKS;
        end else if (!res_sync[1]) begin
            rst_cnt_reg <= `RESET_HOLD_CLKS;
            if (pc_rise) begin
                reset_sync_out <= 1'b1;
            end
        end else if (pc_rise && reset_sync_out) begin
            if (rst_cnt_reg == 3'h1) begin
                reset_sync_out <= 1'b0;
            end
            rst_cnt_reg <= rst_cnt_reg - 3'h1;
        end
    end

    // drive high one clock then float
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_cnt_reg <= `RESET_DRIVE_CLKS;
        end else if (res_edge) begin
            drive_cnt_reg <= `RESET_DRIVE_CLKS;
        end else if (reset_sync_out && pc_rise && drive_cnt_reg != 2'h0) begin
            drive_cnt_reg <= drive_cnt_reg - 2'h1;
        end
    end

    // async ready mid T2, T3, wait
    // rising edge sticks until cycle end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            async_ready_in_reg <= 1'b0;
        end else if (state_reg == clock_bus_pkg::ST_T4) begin
            async_ready_in_reg <= 1'b0;
        end else if (pc_fall && !async_ready_in_reg && (state_reg == clock_bus_pkg::ST_T2
                || state_reg == clock_bus_pkg::ST_T3
                || state_reg == clock_bus_pkg::ST_TW)) begin
            async_ready_in_reg <= async_ready_in_sync[1];
        end
    end

    assign ready_now = async_ready_in_reg || sync_ready_in_sync[1];

    assign grant_ok = hold_sync[1] && !keep_reg;
    assign in_cycle = state_reg != clock_bus_pkg::ST_IDLE
        && state_reg != clock_bus_pkg::ST_FLOAT
        && state_reg != clock_bus_pkg::ST_HOLD;

    // Bus cycle sequencer on processor clock rising edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= clock_bus_pkg::ST_IDLE;
        end else if (reset_sync_out) begin
            state_reg <= clock_bus_pkg::ST_IDLE;
        end else if (pc_rise) begin
            case (state_reg)
                clock_bus_pkg::ST_IDLE: begin
                    if (grant_ok) begin
                        state_reg <= clock_bus_pkg::ST_FLOAT;
                    end else if (req_valid) begin
                        state_reg <= clock_bus_pkg::ST_T1;
                    end
                end
                clock_bus_pkg::ST_T1: state_reg <= clock_bus_pkg::ST_T2;
                clock_bus_pkg::ST_T2: state_reg <= clock_bus_pkg::ST_T3;
                clock_bus_pkg::ST_T3,
                clock_bus_pkg::ST_TW: begin
                    if (ready_now) begin
                        state_reg <= clock_bus_pkg::ST_T4;
                    end else begin
                        state_reg <= clock_bus_pkg::ST_TW;
                    end
                end
                clock_bus_pkg::ST_T4: state_reg <= clock_bus_pkg::ST_IDLE;
                clock_bus_pkg::ST_FLOAT: state_reg <= clock_bus_pkg::ST_HOLD;
                clock_bus_pkg::ST_HOLD: begin
                    if (!hold_sync[1]) begin
                        state_reg <= clock_bus_pkg::ST_IDLE;
                    end
                end
                default: state_reg <= clock_bus_pkg::ST_IDLE;
            endcase
        end
    end

    assign req_taken = pc_rise && !reset_sync_out && !grant_ok && req_valid
        && state_reg == clock_bus_pkg::ST_IDLE;

    // Cycle attributes latched as the cycle starts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            write_reg <= 1'b0;
            lock_reg <= 1'b0;
            status_reg <= `STATUS_PASSIVE;
            addr_reg <= 20'h00000;
            wdata_reg <= 16'h0000;
            bhe_reg <= 1'b1;
        end else if (req_taken) begin
            write_reg <= req_write;
            lock_reg <= req_lock;
            status_reg <= req_status;
            addr_reg <= req_addr;
            wdata_reg <= req_wdata;
            bhe_reg <= req_bhe_n;
        end
    end

    // locked or DMA run blocks grant
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            keep_reg <= 1'b0;
        end else if (reset_sync_out) begin
            keep_reg <= 1'b0;
        end else if (req_taken) begin
            keep_reg <= req_lock || req_dma_more;
        end
    end

    // Read data captured as the ready state ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cyc_rdata <= 16'h0000;
            cyc_done <= 1'b0;
        end else begin
            cyc_done <= pc_rise && state_reg == clock_bus_pkg::ST_T4;
            if (pc_rise && ready_now && !write_reg
                    && (state_reg == clock_bus_pkg::ST_T3
                    || state_reg == clock_bus_pkg::ST_TW)) begin
                cyc_rdata <= ad_sync2;
            end
        end
    end

    // latch strobe in first half of T1
    assign address_latch_strobe = !reset_sync_out && pclk_reg
        && state_reg == clock_bus_pkg::ST_T1;

    // strobes over T2, T3 and waits
    always_comb begin
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        if (!reset_sync_out && (state_reg == clock_bus_pkg::ST_T2
                || state_reg == clock_bus_pkg::ST_T3
                || state_reg == clock_bus_pkg::ST_TW)) begin
            read_strobe_n = write_reg;
            write_strobe_n = !write_reg;
        end
    end

    // status is the only space hint
    assign transceiver_enable_n = reset_sync_out || !(in_cycle
        && state_reg != clock_bus_pkg::ST_T1);
    assign cycle_status = (!reset_sync_out && in_cycle
        && state_reg != clock_bus_pkg::ST_T4) ? status_reg : `STATUS_PASSIVE;
    assign bus_lock_n = reset_sync_out || !(in_cycle && lock_reg);

    assign transfer_direction = write_reg;

    always_comb begin
        strobe_oe = 1'b1;
        status_oe = 1'b1;
        bus_oe = 1'b1;
        if (reset_sync_out) begin
            strobe_oe = drive_cnt_reg != 2'h0;
            status_oe = drive_cnt_reg != 2'h0;
            bus_oe = 1'b0;
        end else if (state_reg == clock_bus_pkg::ST_FLOAT
                || state_reg == clock_bus_pkg::ST_HOLD) begin
            strobe_oe = 1'b0;
            status_oe = 1'b0;
            bus_oe = 1'b0;
        end
    end

    // Address in T1, write data until T4 ends
    always_comb begin
        addr_data_out = addr_reg[15:0];
        addr_data_oe = 1'b0;
        if (bus_oe && state_reg == clock_bus_pkg::ST_T1) begin
            addr_data_oe = 1'b1;
        end else if (bus_oe && write_reg && in_cycle) begin
            addr_data_out = wdata_reg;
            addr_data_oe = 1'b1;
        end
    end

    assign upper_address = addr_reg[19:16];
    assign high_byte_enable_n = bhe_reg;

    assign bus_grant_out = !reset_sync_out && state_reg == clock_bus_pkg::ST_HOLD;

endmodule

// ===== dv/clock_bus_ctrl_asserts.sv
/*
 Port checker for clock_bus_ctrl.
 Assumes the bench oscillator holds each level for 5 clk.
*/
`timescale 1ns/1ps
module clock_bus_ctrl_asserts (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic oscillator_input,
    input wire logic reset_request_n,
    input wire logic processor_clock_out,
    input wire logic reset_sync_out,
    // Bus pins
    input wire logic bus_grant_out,
    input wire logic address_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic transceiver_enable_n,
    input wire logic strobe_oe,
    input wire logic status_oe,
    input wire logic addr_data_oe,
    input wire logic transfer_direction,
    input wire logic bus_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_grant_float;
        bus_grant_out |-> !(addr_data_oe || bus_oe || strobe_oe || status_oe);
    endproperty
    a_grant_float: assert property (p_grant_float) else $error("bus driven in hold");
    property p_grant_late;
        $rose(bus_grant_out) |-> !$past(bus_oe) && !$past(addr_data_oe) && !$past(strobe_oe);
    endproperty
    a_grant_late: assert property (p_grant_late) else $error("grant before float");
    property p_latch;
        address_latch_strobe |-> processor_clock_out && addr_data_oe && !bus_grant_out;
    endproperty
    a_latch: assert property (p_latch) else $error("latch strobe misplaced");
    property p_strobes;
        strobe_oe && !(read_strobe_n && write_strobe_n)
            |-> !transceiver_enable_n && bus_oe && (transfer_direction == read_strobe_n);
    endproperty
    a_strobes: assert property (p_strobes) else $error("enable or direction wrong");
    property p_clock_edge;
        $rose(processor_clock_out) |-> !oscillator_input;
    endproperty
    a_clock_edge: assert property (p_clock_edge) else $error("clock rose off osc fall");
    property p_clock_sym;
        @(posedge clk) disable iff (!rst_n || !reset_request_n)
        $changed(processor_clock_out) |=> $stable(processor_clock_out)[*7];
    endproperty
    a_clock_sym: assert property (p_clock_sym) else $error("clock half period short");
    property p_reset_lag;
        $fell(reset_request_n) |-> ##[1:50] reset_sync_out;
    endproperty
    a_reset_lag: assert property (p_reset_lag) else $error("reset out late");
    property p_reset_quiet;
        reset_sync_out |-> !address_latch_strobe && !bus_grant_out && read_strobe_n
            && write_strobe_n && transceiver_enable_n;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("pins active in reset");
endmodule

bind clock_bus_ctrl clock_bus_ctrl_asserts chk_u (
    .clk, .rst_n, .oscillator_input, .reset_request_n, .processor_clock_out,
    .reset_sync_out, .bus_grant_out, .address_latch_strobe, .read_strobe_n,
    .write_strobe_n, .transceiver_enable_n, .strobe_oe, .status_oe, .addr_data_oe,
    .transfer_direction, .bus_oe
);

// ===== dv/local_bus_partner.sv
/*
 Far-side memory: answers each cycle with ready and read data.
 Assumes the bench resolves addr_data_in from addr_data_oe.
*/
`timescale 1ns/1ps
module local_bus_partner (
    // Bus pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic processor_clock_out,
    input wire logic address_latch_strobe,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [15:0] addr_data_out,
    // Bench controls
    input wire logic [3:0] wait_states,
    input wire logic use_async,
    // Answers
    output logic async_ready_in,
    output logic sync_ready_in,
    output logic [15:0] rd_bus,
    output logic [15:0] wr_seen
);
    logic pclk_reg;
    logic [3:0] rise_reg;
    logic [15:0] addr_reg;
    logic active;
    logic ready;
    assign active = !(read_strobe_n && write_strobe_n);
    // ready drops with the strobe, on a clk edge
    assign ready = active && (rise_reg >= wait_states + 4'h2);
    assign async_ready_in = use_async && ready;
    assign sync_ready_in = !use_async && ready;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pclk_reg <= 1'b0;
            rise_reg <= 4'h0;
            addr_reg <= 16'h0000;
            rd_bus <= 16'h0000;
            wr_seen <= 16'h0000;
        end else begin
            pclk_reg <= processor_clock_out;
            if (!active) begin
                rise_reg <= 4'h0;
            end else if (processor_clock_out && !pclk_reg && rise_reg != 4'hF) begin
                rise_reg <= rise_reg + 4'h1;
            end
            if (address_latch_strobe) begin
                addr_reg <= addr_data_out;
            end
            if (!write_strobe_n) begin
                wr_seen <= addr_data_out;
            end
            // Released bus toggles so stale data never matches
            rd_bus <= !read_strobe_n ? (addr_reg ^ 16'h5AC3) : ~rd_bus;
        end
    end
endmodule

// ===== dv/clock_bus_ctrl_test.sv
/*
 Bench for clock_bus_ctrl with the far-side memory model.
 Assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ps
module clock_bus_ctrl_test;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic oscillator_input = 1'b1;
    logic [2:0] osc_cnt = 3'h0;
    logic reset_request_n = 1'b1;
    logic bus_request_in = 1'b0;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [2:0] req_status = 3'h0;
    logic [19:0] req_addr = 20'h00000;
    logic [15:0] req_wdata = 16'h0000;
    logic req_lock = 1'b0;
    logic req_dma_more = 1'b0;
    logic [3:0] wait_states = 4'h0;
    logic use_async = 1'b0;
    logic processor_clock_out, reset_sync_out, async_ready_in, sync_ready_in;
    logic bus_grant_out, address_latch_strobe, read_strobe_n, write_strobe_n;
    logic transceiver_enable_n, strobe_oe, status_oe, addr_data_oe, bus_oe;
    logic transfer_direction, req_taken, cyc_done, bus_lock_n;
    logic [3:0] upper_address;
    logic [2:0] cycle_status;
    logic [15:0] addr_data_out, addr_data_in, cyc_rdata, rd_bus, wr_seen;
    int num_errors = 0;
    int total_checks = 0;

    always #2.5 clk = ~clk;
    // Oscillator level held 5 clk
    always @(posedge clk) begin
        osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
        if (osc_cnt == 3'h4) begin
            oscillator_input <= ~oscillator_input;
        end
    end
    assign addr_data_in = addr_data_oe ? addr_data_out : rd_bus;

    clock_bus_ctrl dut_u (
        .clk, .rst_n, .oscillator_input, .reset_request_n, .processor_clock_out,
        .reset_sync_out, .async_ready_in, .sync_ready_in, .bus_request_in,
        .bus_grant_out, .address_latch_strobe, .read_strobe_n, .write_strobe_n,
        .transceiver_enable_n, .strobe_oe, .cycle_status, .bus_lock_n, .status_oe,
        .addr_data_in, .addr_data_out, .addr_data_oe, .upper_address,
        .high_byte_enable_n(), .transfer_direction, .bus_oe, .req_valid, .req_write,
        .req_status, .req_addr, .req_wdata, .req_bhe_n(1'b0), .req_lock,
        .req_dma_more, .req_taken, .cyc_done, .cyc_rdata
    );
    local_bus_partner far_u (
        .clk, .rst_n, .processor_clock_out, .address_latch_strobe, .read_strobe_n,
        .write_strobe_n, .addr_data_out, .wait_states, .use_async, .async_ready_in,
        .sync_ready_in, .rd_bus, .wr_seen
    );

    task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic run_cycle(input logic wr, input logic [2:0] st, input logic [3:0] w,
            input logic as, input logic lk, input logic dm);
        int n;
        int rises;
        logic prev;
        logic lock_seen;
        logic [19:0] a;
        n = 0;
        rises = 0;
        prev = 1'b1;
        lock_seen = 1'b0;
        a = {1'b0, st, 12'hC3A, w};
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_status <= st;
        req_addr <= a;
        req_wdata <= ~a[15:0];
        req_lock <= lk;
        req_dma_more <= dm;
        wait_states <= w;
        use_async <= as;
        do begin
            @(posedge clk);
            n++;
        end while (req_taken !== 1'b1 && n < 400);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (processor_clock_out === 1'b1 && prev === 1'b0) rises++;
            prev = processor_clock_out;
            if (!read_strobe_n || !write_strobe_n) lock_seen = !bus_lock_n;
        end while (cyc_done !== 1'b1 && n < 1000);
        check_word("lock", 16'(lk), 16'(lock_seen));
        check_word("upper address", 16'(a[19:16]), 16'(upper_address));
        check_word("processor clocks", 16'(4 + w), 16'(rises));
        if (wr) check_word("write data", ~a[15:0], wr_seen);
        else check_word("read data", a[15:0] ^ 16'h5AC3, cyc_rdata);
    endtask

    task automatic t_reset_pins();
        int n;
        n = 0;
        check_word("strobe drive", 16'h0001, {15'h0000, strobe_oe});
        check_word("status", 16'h0007, {13'h0000, cycle_status});
        check_word("grant", 16'h0000, {15'h0000, bus_grant_out});
        @(posedge clk);
        rst_n <= 1'b1;
        // Drive window ends on the first processor edge, reset still held
        while (strobe_oe !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check_word("strobe float", 16'h0000, {15'h0000, strobe_oe});
        check_word("status float", 16'h0000, {15'h0000, status_oe});
        check_word("reset held", 16'h0001, {15'h0000, reset_sync_out});
        check_word("read strobe", 16'h0001, {15'h0000, read_strobe_n});
        while (reset_sync_out !== 1'b0 && n < 400) begin
            @(posedge clk);
            n++;
        end
        check_word("reset release", 16'h0000, {15'h0000, reset_sync_out});
    endtask

    task automatic t_hold();
        int n;
        n = 0;
        @(posedge clk);
        bus_request_in <= 1'b1;
        while (bus_grant_out !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check_word("grant", 16'h0001, {15'h0000, bus_grant_out});
        check_word("bus float", 16'h0000, {15'h0000, bus_oe});
        bus_request_in <= 1'b0;
        repeat (60) @(posedge clk);
        check_word("grant drop", 16'h0000, {15'h0000, bus_grant_out});
    endtask

    task automatic t_locked();
        run_cycle(1'b0, 3'h5, 4'h0, 1'b0, 1'b1, 1'b0);
        bus_request_in <= 1'b1;
        repeat (80) @(posedge clk);
        check_word("grant in lock", 16'h0000, {15'h0000, bus_grant_out});
        run_cycle(1'b1, 3'h6, 4'h1, 1'b0, 1'b0, 1'b1);
        repeat (80) @(posedge clk);
        check_word("grant in dma", 16'h0000, {15'h0000, bus_grant_out});
        run_cycle(1'b0, 3'h4, 4'h0, 1'b1, 1'b0, 1'b0);
        repeat (80) @(posedge clk);
        check_word("grant after", 16'h0001, {15'h0000, bus_grant_out});
        bus_request_in <= 1'b0;
        repeat (60) @(posedge clk);
    endtask

    task automatic t_reset_req();
        int n;
        int hi;
        n = 0;
        hi = 0;
        @(posedge clk);
        reset_request_n <= 1'b0;
        while (reset_sync_out !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check_word("reset lag", 16'h0001, {15'h0000, n <= 50});
        // Six processor clocks of request
        while (n < 120 || (reset_request_n && reset_sync_out === 1'b1 && hi < 1000)) begin
            @(posedge clk);
            n++;
            hi++;
            if (n == 120) reset_request_n <= 1'b1;
        end
        check_word("reset hold", 16'h0001, {15'h0000, hi >= 100});
    endtask

    initial begin
        @(posedge clk);
        t_reset_pins();
        for (int i = 0; i < 7; i++) run_cycle(i[0], 3'(i), 4'(i % 3), i[1], 1'b0, 1'b0);
        t_hold();
        t_locked();
        t_reset_req();
        run_cycle(1'b1, 3'h2, 4'h2, 1'b1, 1'b0, 1'b0);
        close_out();
    end

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        close_out();
    end
endmodule
